// ==== tocr_pkg.sv ====
`default_nettype none
package tocr_pkg;
	// Counter and divider widths
	localparam int unsigned COUNT_W = 16;
	localparam int unsigned DIV_W = 8;
	localparam int unsigned SEL_W = 3;
	// Clock figures
	localparam real CORE_CLK_MHZ = 20.0;
	localparam real IFACE_CLK_MHZ = 13.56;
	// Divider mask seed: selector 0 keeps one low bit, so the rate is half the clock
	localparam logic [DIV_W-1:0] DIV_MASK_SEED = 8'hfe;
	// Reset values
	localparam logic [SEL_W-1:0] RST_TICK_RATE = 3'h0;
	localparam logic RST_PRESCALER_USE = 1'h0;
	localparam logic RST_AUTO_RELOAD = 1'h0;
	localparam logic RST_START_NOW = 1'h0;
	localparam logic [COUNT_W-1:0] RST_COUNT = 16'h0000;
	localparam logic [DIV_W-1:0] RST_DIV = 8'h00;
	localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
	// Selector codes
	localparam logic [SEL_W-1:0] SEL_6M78 = 3'h0;
	localparam logic [SEL_W-1:0] SEL_3M39 = 3'h1;
	localparam logic [SEL_W-1:0] SEL_1M70 = 3'h2;
	localparam logic [SEL_W-1:0] SEL_848K = 3'h3;
	localparam logic [SEL_W-1:0] SEL_424K = 3'h4;
	localparam logic [SEL_W-1:0] SEL_212K = 3'h5;
	localparam logic [SEL_W-1:0] SEL_106K = 3'h6;
	localparam logic [SEL_W-1:0] SEL_53K = 3'h7;
	// Timer run states
	typedef enum logic [0:0] {
		TOCR_IDLE = 1'b0,
		TOCR_RUN = 1'b1
	} tocr_state_t;
endpackage
`default_nettype wire

// ==== tocr_timer.sv ====
`default_nettype none
// Contract
// - Selector picks tick, half clock down to 1/256
// - Selector ignored unless prescaler is enabled
// - Mode 0 at reset counts every clock
// - Mode 1 counts on prescaled tick
// - Without reload, stop and hold zero
// - With reload, reload preset and keep counting
// - Reload control resets to zero
// - Writing start one starts timer at once
//////////////////////////////////////////////////////////////////////////////
module tocr_timer (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_cfg_wr,
	input wire logic [2:0] i_cfg_tick_rate_select,
	input wire logic i_cfg_prescaler_use_select,
	input wire logic i_cfg_auto_reload_on,
	input wire logic i_cfg_start_immediately,
	input wire logic [15:0] i_preset_value,
	output logic [2:0] o_tick_rate_select,
	output logic o_prescaler_use_select,
	output logic o_auto_reload_on,
	output logic o_start_immediately,
	output logic [15:0] o_count_value,
	output logic o_running,
	output logic o_expired
);
	logic [tocr_pkg::SEL_W-1:0] sel_q;
	logic mode_q;
	logic reload_q;
	logic start_q;
	logic [tocr_pkg::COUNT_W-1:0] count_q;
	logic [tocr_pkg::DIV_W-1:0] div_q;
	logic [tocr_pkg::DIV_W-1:0] div_mask;
	logic [tocr_pkg::DIV_W-1:0] div_shift;
	tocr_pkg::tocr_state_t state_q;
	logic expired_q;
	logic start_w;
	logic pre_tick;
	logic tick;
	logic expire_w;
	logic cfg_seen_q;
	logic [8:0] gap_q;
	logic gap_ok_q;

	//////////////////////////////////////////////////////////////////////////
	// Configuration bits
	// reload clears at reset
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			sel_q <= tocr_pkg::RST_TICK_RATE;
			mode_q <= tocr_pkg::RST_PRESCALER_USE;
			reload_q <= tocr_pkg::RST_AUTO_RELOAD;
			start_q <= tocr_pkg::RST_START_NOW;
		end else if (i_cfg_wr) begin
			sel_q <= i_cfg_tick_rate_select;
			mode_q <= i_cfg_prescaler_use_select;
			reload_q <= i_cfg_auto_reload_on;
			start_q <= i_cfg_start_immediately;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			cfg_seen_q <= 1'b0;
		end else if (i_cfg_wr) begin
			cfg_seen_q <= 1'b1;
		end
	end

	assign start_w = i_cfg_wr && i_cfg_start_immediately;

	//////////////////////////////////////////////////////////////////////////
	// Prescaler
	// Divider restarts with the timer so the first tick has full length
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || start_w) begin
			div_q <= tocr_pkg::RST_DIV;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	assign div_shift = tocr_pkg::DIV_MASK_SEED << sel_q;
	assign div_mask = ~div_shift;
	assign pre_tick = ((div_q & div_mask) == div_mask);
	assign tick = mode_q ? pre_tick : 1'b1;

	//////////////////////////////////////////////////////////////////////////
	// Down counter
	// expiry on last tick
	assign expire_w = (state_q == tocr_pkg::TOCR_RUN) && tick && !start_w
		&& (count_q <= tocr_pkg::COUNT_ONE);

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			state_q <= tocr_pkg::TOCR_IDLE;
			count_q <= tocr_pkg::RST_COUNT;
		end else if (start_w) begin
			state_q <= tocr_pkg::TOCR_RUN;
			count_q <= i_preset_value;
		end else if (expire_w) begin
			if (reload_q) begin
				count_q <= i_preset_value;
			end else begin
				state_q <= tocr_pkg::TOCR_IDLE;
				count_q <= tocr_pkg::RST_COUNT;
			end
		end else if ((state_q == tocr_pkg::TOCR_RUN) && tick) begin
			count_q <= count_q - tocr_pkg::COUNT_ONE;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			expired_q <= 1'b0;
		end else begin
			expired_q <= expire_w;
		end
	end

	assign o_tick_rate_select = sel_q;
	assign o_prescaler_use_select = mode_q;
	assign o_auto_reload_on = reload_q;
	assign o_start_immediately = start_q;
	assign o_count_value = count_q;
	assign o_running = (state_q == tocr_pkg::TOCR_RUN);
	assign o_expired = expired_q;

	//////////////////////////////////////////////////////////////////////////
	// Checks
	// Tick spacing is only known once a start or a tick has aligned the divider
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			gap_q <= 9'h001;
			gap_ok_q <= 1'b0;
		end else if (start_w || (!i_cfg_wr && tick)) begin
			gap_q <= 9'h001;
			gap_ok_q <= 1'b1;
		end else if (i_cfg_wr) begin
			gap_q <= 9'h001;
			gap_ok_q <= 1'b0;
		end else begin
			gap_q <= gap_q + 9'h001;
		end
	end

	bypass_step_a: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		!mode_q && o_running && !start_w && (count_q > tocr_pkg::COUNT_ONE)
		|=> count_q == $past(count_q) - tocr_pkg::COUNT_ONE)
		else $error("bypass mode missed a step");

	presc_hold_a: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		mode_q && o_running && !start_w && !div_q[0] |=> $stable(count_q))
		else $error("prescaled count moved off tick");

	half_rate_a: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		mode_q && (sel_q == tocr_pkg::SEL_6M78) && !i_cfg_wr |=> (tick != $past(tick)))
		else $error("fastest prescaled rate wrong");

	tick_gap_a: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		mode_q && tick && gap_ok_q |-> (gap_q == (9'h002 << sel_q)))
		else $error("prescaled tick spacing wrong");

	stop_hold_a: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		expire_w && !reload_q |=> (count_q == 16'h0000) && !o_running && o_expired)
		else $error("timer did not stop at zero");

	reload_a: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		expire_w && reload_q |=> (count_q == $past(i_preset_value)) && o_running)
		else $error("timer did not reload");

	reload_rst_a: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		!cfg_seen_q |-> !reload_q && !start_q && !mode_q)
		else $error("config not at reset value");

	start_now_a: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		start_w |=> o_running && (count_q == $past(i_preset_value)))
		else $error("immediate start failed");

	dec_step_a: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		o_running && tick && !start_w && (count_q > 16'h0001)
		|=> count_q == $past(count_q) - 16'h0001)
		else $error("counter step wrong");

	idle_hold_a: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		!o_running && !start_w |=> !o_running && $stable(count_q))
		else $error("idle timer moved");

	expire_run_a: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		o_expired |-> $past(o_running))
		else $error("expiry without running timer");

	start_rb_a: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		i_cfg_wr |=> (o_start_immediately == $past(i_cfg_start_immediately)))
		else $error("start bit readback wrong");

	cfg_rb_a: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		i_cfg_wr |=> (o_prescaler_use_select == $past(i_cfg_prescaler_use_select))
		&& (o_tick_rate_select == $past(i_cfg_tick_rate_select)))
		else $error("clock config readback wrong");
endmodule
`default_nettype wire

// ==== tocr_timer_tb.sv ====
`default_nettype none
module tocr_timer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic [2:0] sel = 3'h0;
	logic mode = 1'b0;
	logic rld = 1'b0;
	logic go = 1'b0;
	logic [15:0] pre = 16'h0000;
	logic [2:0] q_sel;
	logic q_mode, q_rld, q_go, run, exp_p;
	logic [15:0] cnt;
	int err_total = 0;
	int samples_checked = 0;
	int k;
	tocr_timer uut (.i_core_clk(clk), .i_sys_rst(rst), .i_cfg_wr(wr),
		.i_cfg_tick_rate_select(sel), .i_cfg_prescaler_use_select(mode),
		.i_cfg_auto_reload_on(rld), .i_cfg_start_immediately(go), .i_preset_value(pre),
		.o_tick_rate_select(q_sel), .o_prescaler_use_select(q_mode), .o_auto_reload_on(q_rld),
		.o_start_immediately(q_go), .o_count_value(cnt), .o_running(run), .o_expired(exp_p));
	initial begin
		forever #25 clk = ~clk;
	end
	//////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			err_total++;
			$display("Error %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One write strobe; returns just after the taking edge
	task automatic cfg(input logic [2:0] s, input logic m, r, g, input logic [15:0] p);
		sel = s;
		mode = m;
		rld = r;
		go = g;
		pre = p;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
	endtask
	task automatic end_sim;
		$display("Counts: %0d mismatches in %0d checks", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Whole run is about 550 cycles, so this limit only trips on a hang
	initial begin
		#250000;
		err_total++;
		end_sim();
	end
	//////////////////////////////////////////////////////////////////////////
	initial begin
		tick(5);
		rst = 1'b0;
		chk(q_rld, 1'b0);
		chk(q_go, 1'b0);
		chk(q_mode, 1'b0);
		chk(q_sel, 3'h0);
		$display("Reset values done");
		cfg(3'h5, 1'b0, 1'b0, 1'b1, 16'h0003);
		chk(q_go, 1'b1);
		chk(q_sel, 3'h5);
		chk(cnt, 16'h0003);
		tick(1);
		chk(cnt, 16'h0002);
		tick(1);
		chk(exp_p, 1'b0);
		tick(1);
		chk({cnt, run, exp_p}, {16'h0000, 2'b01});
		tick(1);
		chk(exp_p, 1'b0);
		tick(3);
		chk({cnt, run}, 17'h00000);
		$display("One-shot done");
		cfg(3'h0, 1'b0, 1'b1, 1'b1, 16'h0002);
		chk(q_rld, 1'b1);
		tick(2);
		chk({cnt, run, exp_p}, {16'h0002, 2'b11});
		tick(1);
		chk({cnt, run, exp_p}, {16'h0001, 2'b10});
		$display("Reload done");
		// Mode 0 ignores the selector; mode 1 divides by 2^(sel+1)
		for (int m = 0; m < 2; m++) begin
			for (int s = 0; s < 8; s++) begin
				cfg(s[2:0], m[0], 1'b0, 1'b1, 16'h0001);
				chk(q_mode, m[0]);
				k = 0;
				while (exp_p !== 1'b1 && k < 600) begin
					tick(1);
					k++;
				end
				chk(k[15:0], (m == 0) ? 16'h0001 : 16'h0001 << (s + 1));
			end
		end
		$display("Rate sweep done");
		end_sim();
	end
endmodule
`default_nettype wire
